// ==== pkg/power_ctrl_map.svh ====
`ifndef POWER_CTRL_MAP_SVH
`define POWER_CTRL_MAP_SVH

// Register indices as printed; byte address is four times the index
`define IDX_MAIN_CLOCK_CONFIG 8'h14
`define IDX_PUMP_CLOCK_CONTROL 8'h15
`define IDX_SUPPLY_COMPARATOR_CONTROL 8'h1c
`define IDX_ANALOG_ENABLE_CONTROL 8'h1d
`define IDX_LOWBATT_STATUS 8'h1f
`define IDX_IRQ_STATUS 8'h30
`define IDX_IRQ_ENABLE 8'h31
`define IDX_IRQ_CLEAR 8'h32

// Field positions
`define BIT_MAIN_CLOCK_SOURCE_SELECT 0
`define BIT_DOUBLER_ENABLE 6
`define BIT_DOUBLER_CLOCK_SELECT 0
`define BIT_SUPPLY_OUTPUT_CONNECT 4
`define LSB_LOWBATT_INPUT_SELECT 2
`define BIT_LOWBATT_COMPARE_ENABLE 1
`define BIT_BANDGAP_ENABLE 6
`define BIT_REGULATOR_ENABLE 5
`define BIT_COMMON_VOLTAGE_ENABLE 1
`define BIT_ANALOG_BIAS_ENABLE 0
`define BIT_LOWBATT_RESULT 0

// Writable masks: unimplemented bits ignore writes, read zero
`define MASK_MAIN_CLOCK_CONFIG 8'hef
`define MASK_PUMP_CLOCK_CONTROL 8'h41
`define MASK_SUPPLY_COMPARATOR_CONTROL 8'h1e
`define MASK_ANALOG_ENABLE_CONTROL 8'h63

// Reset values
`define RESET_CONTROL 8'h00

// Doubler clock divisors
`define DIV_MAIN_FAST 100
`define DIV_MAIN_SLOW 200
`define DIV_CRYSTAL 32

`endif

// ==== pkg/power_ctrl_pkg.sv ====
package power_ctrl_pkg;

    typedef struct packed {
        logic doubler_enable;
        logic supply_output_connect;
        logic [1:0] lowbatt_input_select;
        logic lowbatt_compare_enable;
        logic bandgap_enable;
        logic regulator_enable;
        logic common_voltage_enable;
        logic analog_bias_enable;
    } analog_ctrl_type;

    typedef enum logic [1:0] {
        sel_lower_tap,
        sel_higher_tap,
        sel_external_four,
        sel_floating
    } lowbatt_sel_type;

    typedef enum logic [1:0] {
        src_main_div200,
        src_main_div100,
        src_crystal_div32
    } doubler_src_type;

endpackage

// ==== src/clock_divider.sv ====
`timescale 1ns/100ps
`include "power_ctrl_map.svh"

// Divides by a run-time selected even count; output toggles every half period
module clock_divider
import power_ctrl_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic run,
    input wire logic [CNT_W-1:0] half_count,
    output logic clk_out
);

    initial begin
        if (CNT_W < 7) begin
            $error("clock_divider: counter too narrow");
        end
    end

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic clk_r;
    logic clk_nxt;

    always_comb begin
        count_nxt = count_r;
        clk_nxt = clk_r;
        if (!run) begin
            count_nxt = '0;
            clk_nxt = 1'b0;
        end else if (count_r + 1'b1 >= half_count) begin
            count_nxt = '0;
            clk_nxt = ~clk_r;
        end else begin
            count_nxt = count_r + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0;
            clk_r <= 1'b0;
        end else if (enable) begin
            count_r <= count_nxt;
            clk_r <= clk_nxt;
        end
    end

    assign clk_out = clk_r;

endmodule

// ==== src/edge_catcher.sv ====
`timescale 1ns/100ps

// Flags any change of a level input as a one-cycle pulse
module edge_catcher
import power_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic level_in,
    output logic rise,
    output logic fall
);

    logic last_r;
    logic last_nxt;

    always_comb begin
        last_nxt = level_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_r <= 1'b0;
        end else if (enable) begin
            last_r <= last_nxt;
        end
    end

    assign rise = enable & level_in & ~last_r;
    assign fall = enable & ~level_in & last_r;

endmodule

// ==== src/power_system_control_regs.sv ====
`timescale 1ns/100ps
`include "power_ctrl_map.svh"

// How it works
// - Pump control bit 6 enables the voltage doubler, cleared keeps it off.
// - Pump control bit 0 picks main clock over 100 when set, over 200 when clear.
// - Crystal source select forces doubler clock to crystal over 32.
// - Comparator control bit 4 ties regulated supply to the voltage-source output.
// - Bits 3..2 pick lower tap, higher tap, analog input four, or floating.
// - Comparator control bit 1 enables the low-battery comparator.
// - Analog enable bit 6 turns on bandgap and temperature sensor together.
// - Analog enable bit 5 turns on the analog supply regulator.
// - Analog enable bit 1 turns on the common-voltage generator, else floating.
// - Analog enable bit 0 turns on the analog bias circuit.
// - Status bit 0 is read-only comparator result, high above reference.
module power_system_control_regs
import power_ctrl_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic main_clock,
    input wire logic crystal_clock,
    input wire logic lowbatt_result,
    output analog_ctrl_type analog_ctrl,
    output lowbatt_sel_type lowbatt_input_select,
    output logic doubler_clock,
    output logic irq
);

    initial begin
        if (CNT_W < 7) begin
            $error("power_system_control_regs: CNT_W too small");
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register state

    logic [7:0] main_cfg_r, main_cfg_nxt;
    logic [7:0] pump_r, pump_nxt;
    logic [7:0] comp_r, comp_nxt;
    logic [7:0] aen_r, aen_nxt;
    logic [1:0] irq_stat_r, irq_stat_nxt;
    logic [1:0] irq_en_r, irq_en_nxt;
    logic [31:0] prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [9:0] word_idx;
    logic access;
    logic wr;
    logic hit;
    logic [1:0] irq_clr;
    logic lb_rise;
    logic lb_fall;

    assign word_idx = paddr[11:2];
    assign access = psel & penable & ~pready_r;
    assign wr = access & pwrite & pstrb[0];

    // Ready one cycle after the access phase starts; then dropped
    always_comb begin
        hit = 1'b1;
        prdata_nxt = 32'h0000_0000;
        unique case (word_idx)
            {2'b00, `IDX_MAIN_CLOCK_CONFIG}: prdata_nxt[7:0] = main_cfg_r;
            {2'b00, `IDX_PUMP_CLOCK_CONTROL}: prdata_nxt[7:0] = pump_r;
            {2'b00, `IDX_SUPPLY_COMPARATOR_CONTROL}: prdata_nxt[7:0] = comp_r;
            {2'b00, `IDX_ANALOG_ENABLE_CONTROL}: prdata_nxt[7:0] = aen_r;
            {2'b00, `IDX_LOWBATT_STATUS}: prdata_nxt[`BIT_LOWBATT_RESULT] = lowbatt_result;
            {2'b00, `IDX_IRQ_STATUS}: prdata_nxt[1:0] = irq_stat_r;
            {2'b00, `IDX_IRQ_ENABLE}: prdata_nxt[1:0] = irq_en_r;
            {2'b00, `IDX_IRQ_CLEAR}: prdata_nxt = 32'h0000_0000;
            default: hit = 1'b0;
        endcase
        if (!access || pwrite) begin
            prdata_nxt = 32'h0000_0000;
        end
        pready_nxt = access;
        pslverr_nxt = access & ~hit;
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers

    always_comb begin
        main_cfg_nxt = main_cfg_r;
        pump_nxt = pump_r;
        comp_nxt = comp_r;
        aen_nxt = aen_r;
        irq_en_nxt = irq_en_r;
        irq_clr = 2'b00;
        if (wr) begin
            unique case (word_idx)
                {2'b00, `IDX_MAIN_CLOCK_CONFIG}: main_cfg_nxt = pwdata[7:0] & `MASK_MAIN_CLOCK_CONFIG;
                // only enable and clock select stored
                {2'b00, `IDX_PUMP_CLOCK_CONTROL}: pump_nxt = pwdata[7:0] & `MASK_PUMP_CLOCK_CONTROL;
                {2'b00, `IDX_SUPPLY_COMPARATOR_CONTROL}: comp_nxt = pwdata[7:0] & `MASK_SUPPLY_COMPARATOR_CONTROL;
                {2'b00, `IDX_ANALOG_ENABLE_CONTROL}: aen_nxt = pwdata[7:0] & `MASK_ANALOG_ENABLE_CONTROL;
                {2'b00, `IDX_IRQ_ENABLE}: irq_en_nxt = pwdata[1:0];
                {2'b00, `IDX_IRQ_CLEAR}: irq_clr = pwdata[1:0];
                default: ;
            endcase
        end
        // Set beats clear so a comparator edge during a clear is kept
        irq_stat_nxt = (irq_stat_r & ~irq_clr) | {lb_fall, lb_rise};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_cfg_r <= `RESET_CONTROL;
            pump_r <= `RESET_CONTROL;
            comp_r <= `RESET_CONTROL;
            aen_r <= `RESET_CONTROL;
            irq_stat_r <= 2'b00;
            irq_en_r <= 2'b00;
            prdata <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (clk_en) begin
            main_cfg_r <= main_cfg_nxt;
            pump_r <= pump_nxt;
            comp_r <= comp_nxt;
            aen_r <= aen_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            prdata <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////
    // Analog control outputs, registered

    analog_ctrl_type ctrl_nxt;
    logic irq_nxt;

    always_comb begin
        // doubler enable; is software's to keep clear for external supply
        ctrl_nxt.doubler_enable = pump_r[`BIT_DOUBLER_ENABLE];
        ctrl_nxt.supply_output_connect = comp_r[`BIT_SUPPLY_OUTPUT_CONNECT];
        ctrl_nxt.lowbatt_input_select = comp_r[`LSB_LOWBATT_INPUT_SELECT +: 2];
        ctrl_nxt.lowbatt_compare_enable = comp_r[`BIT_LOWBATT_COMPARE_ENABLE];
        // bandgap and sensor share one enable
        ctrl_nxt.bandgap_enable = aen_r[`BIT_BANDGAP_ENABLE];
        ctrl_nxt.regulator_enable = aen_r[`BIT_REGULATOR_ENABLE];
        ctrl_nxt.common_voltage_enable = aen_r[`BIT_COMMON_VOLTAGE_ENABLE];
        // bias circuit; ordering is left to software
        ctrl_nxt.analog_bias_enable = aen_r[`BIT_ANALOG_BIAS_ENABLE];
        irq_nxt = |(irq_stat_r & irq_en_r);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_ctrl <= '0;
            lowbatt_input_select <= sel_lower_tap;
            irq <= 1'b0;
        end else if (clk_en) begin
            analog_ctrl <= ctrl_nxt;
            // selector decoded onto its own typed port
            lowbatt_input_select <= lowbatt_sel_type'(ctrl_nxt.lowbatt_input_select);
            irq <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Doubler clock: main and crystal are sampled as synchronous inputs,
    // so the divider counts their rising edges

    doubler_src_type src;
    logic [CNT_W-1:0] half_count;
    logic src_level;
    logic src_rise;
    logic div_clk;
    logic doubler_clock_nxt;

    always_comb begin
        // crystal source overrides the clock select bit
        if (main_cfg_r[`BIT_MAIN_CLOCK_SOURCE_SELECT]) begin
            src = src_crystal_div32;
        // fast or slow division of the main clock
        end else if (pump_r[`BIT_DOUBLER_CLOCK_SELECT]) begin
            src = src_main_div100;
        end else begin
            src = src_main_div200;
        end
        unique case (src)
            src_crystal_div32: begin
                src_level = crystal_clock;
                half_count = CNT_W'(`DIV_CRYSTAL / 2);
            end
            src_main_div100: begin
                src_level = main_clock;
                half_count = CNT_W'(`DIV_MAIN_FAST / 2);
            end
            default: begin
                src_level = main_clock;
                half_count = CNT_W'(`DIV_MAIN_SLOW / 2);
            end
        endcase
    end

    edge_catcher src_edge (
        .pclk(pclk),
        .presetn(presetn),
        .enable(clk_en),
        .level_in(src_level),
        .rise(src_rise),
        .fall()
    );

    edge_catcher lb_edge (
        .pclk(pclk),
        .presetn(presetn),
        .enable(clk_en),
        .level_in(lowbatt_result),
        .rise(lb_rise),
        .fall(lb_fall)
    );

    // divider held in reset while the doubler is off
    clock_divider #(
        .CNT_W(CNT_W)
    ) pump_div (
        .pclk(pclk),
        .presetn(presetn),
        .enable(clk_en & (src_rise | ~pump_r[`BIT_DOUBLER_ENABLE])),
        .run(pump_r[`BIT_DOUBLER_ENABLE]),
        .half_count(half_count),
        .clk_out(div_clk)
    );

    assign doubler_clock_nxt = div_clk;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            doubler_clock <= 1'b0;
        end else if (clk_en) begin
            doubler_clock <= doubler_clock_nxt;
        end
    end

endmodule

// ==== verif/power_system_control_regs_checker.sv ====
`timescale 1ns/100ps
module power_system_control_regs_checker
import power_ctrl_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic main_clock,
    input wire logic crystal_clock,
    input wire logic lowbatt_result,
    input wire analog_ctrl_type analog_ctrl,
    input wire lowbatt_sel_type lowbatt_input_select,
    input wire logic doubler_clock,
    input wire logic irq
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
wire logic take = psel && penable && !pready && clk_en;
// Strobe lane 0 carries the only data byte
wire logic wr_ok = take && pwrite && pstrb[0];
////////////////////////////////////////
property p_rdy;
    take |=> pready ##1 !pready;
endproperty
a_rdy: assert property (p_rdy) else $error("pready not a single pulse after take");
property p_err;
    take && !(paddr[11:2] inside {10'h014, 10'h015, 10'h01c, 10'h01d, 10'h01f, 10'h030, 10'h031, 10'h032})
        |=> pslverr && prdata == 32'h0000_0000;
endproperty
a_err: assert property (p_err) else $error("unmapped access not refused");
property p_idle;
    !pready |-> prdata == 32'h0000_0000 && !pslverr;
endproperty
a_idle: assert property (p_idle) else $error("read bus busy outside answer");
property p_hi;
    pready |-> prdata[31:8] == 24'h00_0000;
endproperty
a_hi: assert property (p_hi) else $error("upper read bits not zero");
property p_pump;
    wr_ok && paddr == 12'h054 |-> ##2 analog_ctrl.doubler_enable == $past(pwdata[6], 2);
endproperty
a_pump: assert property (p_pump) else $error("doubler enable does not follow write");
property p_cmp;
    wr_ok && paddr == 12'h070 |-> ##2 {analog_ctrl.supply_output_connect, analog_ctrl.lowbatt_input_select,
        analog_ctrl.lowbatt_compare_enable} == $past(pwdata[4:1], 2);
endproperty
a_cmp: assert property (p_cmp) else $error("comparator controls do not follow write");
property p_aen;
    wr_ok && paddr == 12'h074 |-> ##2 {analog_ctrl.bandgap_enable, analog_ctrl.regulator_enable,
        analog_ctrl.common_voltage_enable, analog_ctrl.analog_bias_enable}
        == {$past(pwdata[6:5], 2), $past(pwdata[1:0], 2)};
endproperty
a_aen: assert property (p_aen) else $error("analog enables do not follow write");
property p_sel;
    lowbatt_input_select == analog_ctrl.lowbatt_input_select;
endproperty
a_sel: assert property (p_sel) else $error("selector outputs disagree");
property p_off;
    !analog_ctrl.doubler_enable && !$past(analog_ctrl.doubler_enable) |-> !doubler_clock;
endproperty
a_off: assert property (p_off) else $error("doubler clock runs while disabled");
property p_stat;
    take && !pwrite && paddr == 12'h07c |=> prdata[7:1] == 7'h00;
endproperty
a_stat: assert property (p_stat) else $error("status spare bits not zero");
c_wr: cover property (wr_ok);
c_err: cover property (pready && pslverr);
c_irq: cover property ($rose(irq));
endmodule

// ==== verif/tb_power_system_control_regs.sv ====
`timescale 1ns/100ps
module tb_power_system_control_regs
import power_ctrl_pkg::*;
;
logic pclk = 1'b0;
logic presetn = 1'b0;
logic clk_en = 1'b1;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0000_0000;
logic [3:0] pstrb = 4'h0;
logic main_clock = 1'b0;
logic crystal_clock = 1'b0;
logic lowbatt_result = 1'b0;
logic [1:0] xcnt = 2'h0;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic doubler_clock;
logic irq;
analog_ctrl_type analog_ctrl;
lowbatt_sel_type lowbatt_input_select;
logic [31:0] rdat;
logic rerr;
int n_errors = 0;
int checked = 0;
logic [11:0] regs [4] = '{12'h050, 12'h054, 12'h070, 12'h074};
logic [7:0] masks [4] = '{8'hef, 8'h41, 8'h1e, 8'h63};
always #5 pclk = ~pclk;
// Main source rises every 2 cycles, crystal every 4
always @(posedge pclk) begin
    main_clock <= ~main_clock;
    xcnt <= xcnt + 2'h1;
    crystal_clock <= xcnt[1];
end
power_system_control_regs #(.CNT_W(8)) power_system_control_regs_inst (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_clock(main_clock),
    .crystal_clock(crystal_clock), .lowbatt_result(lowbatt_result), .analog_ctrl(analog_ctrl),
    .lowbatt_input_select(lowbatt_input_select), .doubler_clock(doubler_clock), .irq(irq));
////////////////////////////////////////
task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
        n_errors++;
        $display("mismatch %s expected %h seen %h", what, exp, got);
    end
endtask
// One idle cycle after each transfer keeps every driver change a clean edge apart
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
        @(posedge pclk);
        n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    cmp("pready", 32'h0000_0001, 32'(pready));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
endtask
task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    cmp(what, exp, rdat);
endtask
task automatic period(input logic [31:0] exp, input string what);
    int n;
    logic v;
    n = 0;
    for (int k = 0; k < 3; k++) begin
        v = doubler_clock;
        n = 0;
        while (doubler_clock === v && n < 1000) begin
            @(posedge pclk);
            n++;
        end
    end
    cmp(what, exp, 32'(n));
endtask
////////////////////////////////////////
task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
        rd(regs[i], 32'h0000_0000, "reset value");
        wr(regs[i], 32'hffff_ffff);
        rd(regs[i], {24'h00_0000, masks[i]}, "writable bits");
    end
    cmp("all controls set", 32'h0000_01ff, 32'(analog_ctrl));
    for (int i = 0; i < 4; i++) wr(regs[i], 32'h0000_0000);
    cmp("all controls clear", 32'h0000_0000, 32'(analog_ctrl));
endtask
task automatic t_sel;
    for (int i = 0; i < 4; i++) begin
        wr(12'h070, 32'(i << 2));
        cmp("input select", 32'(i), 32'(lowbatt_input_select));
    end
endtask
task automatic t_refuse;
    apb(1'b1, 12'h054, 32'h0000_0041, 4'he);
    rd(12'h054, 32'h0000_0000, "strobe off write");
    apb(1'b0, 12'h100, 32'h0000_0000, 4'h0);
    cmp("unmapped error", 32'h0000_0001, 32'(rerr));
    cmp("unmapped data", 32'h0000_0000, rdat);
    wr(12'h07c, 32'h0000_00ff);
    rd(12'h07c, 32'h0000_0000, "status read only");
endtask
task automatic t_status;
    lowbatt_result <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(12'h07c, 32'h0000_0001, "result high");
    lowbatt_result <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(12'h07c, 32'h0000_0000, "result low");
endtask
task automatic t_irq;
    wr(12'h070, 32'h0000_0002);
    wr(12'h0c8, 32'h0000_0003);
    rd(12'h0c0, 32'h0000_0000, "events cleared");
    lowbatt_result <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(12'h0c0, 32'h0000_0001, "rise event");
    cmp("masked irq", 32'h0000_0000, 32'(irq));
    wr(12'h0c4, 32'h0000_0001);
    cmp("enabled irq", 32'h0000_0001, 32'(irq));
    wr(12'h0c8, 32'h0000_0001);
    cmp("cleared irq", 32'h0000_0000, 32'(irq));
    rd(12'h0c8, 32'h0000_0000, "clear reads zero");
    lowbatt_result <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(12'h0c0, 32'h0000_0002, "fall event");
endtask
task automatic t_dbl;
    wr(12'h054, 32'h0000_0040);
    period(32'd200, "main over 200");
    wr(12'h054, 32'h0000_0041);
    period(32'd100, "main over 100");
    wr(12'h050, 32'h0000_0001);
    period(32'd64, "crystal over 32");
    wr(12'h050, 32'h0000_0000);
    wr(12'h054, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    cmp("doubler stopped", 32'h0000_0000, 32'(doubler_clock));
endtask
// A low clock enable must hold the divider where it stands
task automatic t_freeze;
    logic v;
    wr(12'h054, 32'h0000_0040);
    clk_en <= 1'b0;
    @(posedge pclk);
    v = doubler_clock;
    repeat (300) @(posedge pclk);
    cmp("frozen doubler clock", 32'(v), 32'(doubler_clock));
    clk_en <= 1'b1;
    period(32'd200, "thawed main over 200");
    wr(12'h054, 32'h0000_0000);
endtask
task automatic results;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
////////////////////////////////////////
initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_sel;
    t_refuse;
    t_status;
    t_irq;
    t_dbl;
    t_freeze;
    results;
end
initial begin
    repeat (20000) @(posedge pclk);
    cmp("watchdog", 32'h0000_0000, 32'h0000_0001);
    results;
end
endmodule
bind power_system_control_regs power_system_control_regs_checker #(.CNT_W(CNT_W)) chk_inst (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_clock(main_clock), .crystal_clock(crystal_clock), .lowbatt_result(lowbatt_result),
    .analog_ctrl(analog_ctrl), .lowbatt_input_select(lowbatt_input_select),
    .doubler_clock(doubler_clock), .irq(irq));
